// *** include/serial_support_cfg.svh ***
// Offsets, field positions, reset values and timing counts
// Assumes a byte-addressed APB map and a 100 MHz pclk
`ifndef SERIAL_SUPPORT_CFG_SVH
`define SERIAL_SUPPORT_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_RECOVERY 8'h60
`define OFF_START_A 8'h70
`define OFF_START_B 8'h80
`define OFF_DETECT 8'h90
`define OFF_TIMER 8'hA0
`define CELL_SPAN_END 8'h60

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define IRC_MSB 5
`define START_BIT 0
`define DET_A_BIT 1
`define DET_B_BIT 0
`define TSEL_BIT 16
`define TVAL_MSB 7
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define MARK_BITS 15
`define BIT_TIME_NS 4340
`define PCLK_NS 10
`define PCLK_HZ 100000000
`define TICK_HZ 921600

`endif

// *** include/serial_support_pkg.sv ***
// Types shared by the support block and its channel watchers
// Assumes serial_support_cfg.svh for all numeric constants
package serial_support_pkg;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_cell = 2'b01,
		st_done = 2'b10
	} apb_state_type;

	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic [7:0] wdata;
	} cell_req_type;

endpackage : serial_support_pkg

// *** rtl/packet_abort_watcher.sv ***
// One channel of the packet abort watcher
// Assumes line_in is an asynchronous pin; cell_* are on pclk
`timescale 1ns/1ps
`include "serial_support_cfg.svh"

module packet_abort_watcher #(
	parameter int BIT_CYCLES = `BIT_TIME_NS / `PCLK_NS,
	parameter int MARK_BITS = `MARK_BITS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic line_in,
	input wire logic cell_rts,
	input wire logic cell_txd,
	output logic rts_o,
	output logic rts_oe_n,
	output logic txd_o,
	output logic txd_oe_n,
	output logic detect
);
	import serial_support_pkg::*;

	if (BIT_CYCLES < 2 || MARK_BITS < 1 || MARK_BITS > 255)
		$error("packet_abort_watcher: bad parameters");

	logic s1_r, s2_r, detect_r;
	logic [15:0] bit_cnt_r;
	logic [7:0] mark_cnt_r;
	logic bit_end;
	logic watching;

	assign watching = start && !detect_r;
	assign bit_end = bit_cnt_r == 16'(BIT_CYCLES - 1);

	// ----------------------------------------
	// Line sampling
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
		end else begin
			s1_r <= line_in;
			s2_r <= s1_r;
		end
	end

	// Mark bits sampled once per bit time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt_r <= 16'h0000;
			mark_cnt_r <= 8'h00;
		end else if (!watching) begin
			bit_cnt_r <= 16'h0000;
			mark_cnt_r <= 8'h00;
		end else if (bit_end) begin
			bit_cnt_r <= 16'h0000;
			mark_cnt_r <= s2_r ? mark_cnt_r + 8'h01 : 8'h00;
		end else begin
			bit_cnt_r <= bit_cnt_r + 16'h0001;
		end
	end

	// ----------------------------------------
	// Detect flag and port takeover
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			detect_r <= 1'b0;
		end else if (watching && mark_cnt_r == 8'(MARK_BITS)) begin
			detect_r <= 1'b1;
		end else if (!start) begin
			detect_r <= 1'b0;
		end
	end

	// Watcher holds RTS asserted, then floats the port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rts_o <= 1'b0;
			rts_oe_n <= 1'b0;
			txd_o <= 1'b1;
			txd_oe_n <= 1'b0;
		end else begin
			rts_o <= start ? 1'b1 : cell_rts;
			rts_oe_n <= detect_r;
			txd_o <= cell_txd;
			txd_oe_n <= detect_r;
		end
	end

	assign detect = detect_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_detect_armed: assert property ($rose(detect_r) |->
		$past(start) && $past(mark_cnt_r) == 8'(MARK_BITS))
		else $error("detect rose without arming");
	a_detect_holds: assert property (detect_r && start |=> detect_r)
		else $error("detect dropped while start set");
	a_port_release: assert property ($rose(detect_r) |=>
		rts_oe_n && txd_oe_n)
		else $error("port not released after detect");
	a_rts_taken: assert property (start |=> rts_o)
		else $error("rts not driven while armed");
	c_detect: cover property ($rose(detect_r));

endmodule : packet_abort_watcher

// *** rtl/serial_cell_shared_support.sv ***
// Shared support logic in front of a two-channel serial cell
// Assumes an APB master on pclk and a cell bus on the same clock;
// rxd_* and ext_clk are asynchronous pins.
//
// What this block does
// - Six-bit recovery count register sets access spacing
// - Each cell access reloads and starts recovery timer
// - Next cell access waits for timer zero
// - Start A drives RTS, watches for marks
// - Fifteen marks: float port, raise detect flags
// - Start B arms a second, identical watcher for B
// - Detect register: A in bit1, B bit0
// - Reset clears both detect flags
// - Detect only after arming, then abort seen
// - Detect holds until software clears start
// - Clock select one: count external clock rising edges
// - Clock select zero: count 921.6 kHz tick
// - Timer low byte loads, reads live count
// - Timer reaching zero sets transmit status bit7
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "serial_support_cfg.svh"

module serial_cell_shared_support
	import serial_support_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int BIT_CYCLES = `BIT_TIME_NS / `PCLK_NS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output cell_req_type cell_cmd,
	output logic cell_req,
	input wire logic cell_ack,
	input wire logic [7:0] cell_rdata,
	input wire logic ext_clk,
	input wire logic cell_rts_a,
	input wire logic cell_txd_a,
	input wire logic rxd_a,
	output logic rts_a,
	output logic rts_a_oe_n,
	output logic txd_a,
	output logic txd_a_oe_n,
	input wire logic cell_rts_b,
	input wire logic cell_txd_b,
	input wire logic rxd_b,
	output logic rts_b,
	output logic rts_b_oe_n,
	output logic txd_b,
	output logic txd_b_oe_n,
	output logic abort_status_a,
	output logic abort_status_b,
	output logic tx_status_timer
);

	if (ADDR_W < 8 || BIT_CYCLES < 2)
		$error("serial_cell_shared_support: bad parameters");

	apb_state_type state_r;
	logic [5:0] irc_r;
	logic [5:0] recov_r;
	logic start_a_r, start_b_r;
	logic tsel_r;
	logic [7:0] timer_r;
	logic [31:0] acc_r;
	logic tick_r;
	logic ext_s1_r, ext_s2_r, ext_s3_r;
	logic [7:0] addr8;
	logic hi_zero;
	logic cell_hit, own_hit;
	logic setup, wr_en, cell_done;
	logic wr_timer, dec_en;
	logic det_a, det_b;
	logic [31:0] rd_word;

	assign addr8 = paddr[7:0];
	assign hi_zero = (paddr >> 8) == '0;
	assign cell_hit = hi_zero && addr8 < `CELL_SPAN_END;
	assign setup = psel && !penable && state_r == st_idle;
	assign cell_done = state_r == st_cell && cell_req && cell_ack;
	assign wr_en = state_r == st_done && psel && penable && pwrite
		&& own_hit;
	assign wr_timer = wr_en && addr8 == `OFF_TIMER;

	// ----------------------------------------
	// Address decode and read mux
	// ----------------------------------------
	always_comb begin
		own_hit = hi_zero;
		rd_word = `RST_WORD;
		unique case (addr8)
			`OFF_RECOVERY: rd_word[`IRC_MSB:0] = irc_r;
			`OFF_START_A: rd_word[`START_BIT] = start_a_r;
			`OFF_START_B: rd_word[`START_BIT] = start_b_r;
			`OFF_DETECT: begin
				rd_word[`DET_A_BIT] = det_a;
				rd_word[`DET_B_BIT] = det_b;
			end
			`OFF_TIMER: begin
				rd_word[`TSEL_BIT] = tsel_r;
				rd_word[`TVAL_MSB:0] = timer_r;
			end
			default: own_hit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// APB slave sequencing
	// ----------------------------------------
	// Own registers answer one cycle after setup; cell accesses
	// wait for recovery and the cell's acknowledge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= st_idle;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `RST_WORD;
		end else begin
			unique case (state_r)
				st_idle: begin
					if (setup && cell_hit) begin
						state_r <= st_cell;
					end else if (setup) begin
						state_r <= st_done;
						pready <= 1'b1;
						pslverr <= !own_hit;
						prdata <= pwrite ? `RST_WORD : rd_word;
					end
				end
				st_cell: begin
					if (cell_done) begin
						state_r <= st_done;
						pready <= 1'b1;
						pslverr <= 1'b0;
						prdata <= {24'h00_0000, cell_rdata};
					end
				end
				st_done: begin
					state_r <= st_idle;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
				default: state_r <= st_idle;
			endcase
		end
	end

	// ----------------------------------------
	// Cell access and recovery spacing
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cell_req <= 1'b0;
			cell_cmd <= '0;
		end else if (cell_done) begin
			cell_req <= 1'b0;
		end else if (state_r == st_cell && !cell_req
			&& recov_r == 6'h00) begin
			cell_req <= 1'b1;
			cell_cmd.addr <= addr8;
			cell_cmd.write <= pwrite;
			cell_cmd.wdata <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			recov_r <= 6'h00;
		end else if (cell_done) begin
			recov_r <= irc_r;
		end else if (recov_r != 6'h00) begin
			recov_r <= recov_r - 6'h01;
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irc_r <= 6'h00;
			start_a_r <= 1'b0;
			start_b_r <= 1'b0;
			tsel_r <= 1'b0;
		end else if (wr_en) begin
			unique case (addr8)
				`OFF_RECOVERY: irc_r <= pwdata[`IRC_MSB:0];
				`OFF_START_A: start_a_r <= pwdata[`START_BIT];
				`OFF_START_B: start_b_r <= pwdata[`START_BIT];
				`OFF_TIMER: tsel_r <= pwdata[`TSEL_BIT];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Timer clock sources
	// ----------------------------------------
	// Fractional accumulator keeps the tick exact on average;
	// single ticks jitter by one pclk.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_r <= `RST_WORD;
			tick_r <= 1'b0;
		end else if (acc_r + `TICK_HZ >= `PCLK_HZ) begin
			acc_r <= acc_r + `TICK_HZ - `PCLK_HZ;
			tick_r <= 1'b1;
		end else begin
			acc_r <= acc_r + `TICK_HZ;
			tick_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
		end else begin
			ext_s1_r <= ext_clk;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
		end
	end

	// External clock must stay below pclk/4 to be seen
	assign dec_en = tsel_r ? (ext_s2_r && !ext_s3_r) : tick_r;

	// ----------------------------------------
	// General down timer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_r <= `RST_BYTE;
		end else if (wr_timer) begin
			timer_r <= pwdata[`TVAL_MSB:0];
		end else if (dec_en && timer_r != 8'h00) begin
			timer_r <= timer_r - 8'h01;
		end
	end

	// Reaching zero wins over a same-cycle reload
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_status_timer <= 1'b0;
		end else if (dec_en && timer_r == 8'h01) begin
			tx_status_timer <= 1'b1;
		end else if (wr_timer) begin
			tx_status_timer <= 1'b0;
		end
	end

	// ----------------------------------------
	// Channel watchers
	// ----------------------------------------
	packet_abort_watcher #(
		.BIT_CYCLES(BIT_CYCLES),
		.MARK_BITS(`MARK_BITS)
	) u_watch_a (
		.pclk(pclk),
		.presetn(presetn),
		.start(start_a_r),
		.line_in(rxd_a),
		.cell_rts(cell_rts_a),
		.cell_txd(cell_txd_a),
		.rts_o(rts_a),
		.rts_oe_n(rts_a_oe_n),
		.txd_o(txd_a),
		.txd_oe_n(txd_a_oe_n),
		.detect(det_a)
	);

	packet_abort_watcher #(
		.BIT_CYCLES(BIT_CYCLES),
		.MARK_BITS(`MARK_BITS)
	) u_watch_b (
		.pclk(pclk),
		.presetn(presetn),
		.start(start_b_r),
		.line_in(rxd_b),
		.cell_rts(cell_rts_b),
		.cell_txd(cell_txd_b),
		.rts_o(rts_b),
		.rts_oe_n(rts_b_oe_n),
		.txd_o(txd_b),
		.txd_oe_n(txd_b_oe_n),
		.detect(det_b)
	);

	assign abort_status_a = det_a;
	assign abort_status_b = det_b;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_recov_reserved: assert property (pready && !pwrite
		&& addr8 == `OFF_RECOVERY |-> prdata[7:6] == 2'b00)
		else $error("recovery reserved bits not zero");
	a_recov_reload: assert property (cell_done |=>
		recov_r == $past(irc_r))
		else $error("recovery timer not reloaded");
	a_access_spacing: assert property ($rose(cell_req) |->
		recov_r == 6'h00 && $past(recov_r) <= 6'h01)
		else $error("cell access before recovery ended");
	a_detect_map: assert property (pready && !pwrite
		&& addr8 == `OFF_DETECT
		|-> prdata == {30'h0, $past(det_a), $past(det_b)})
		else $error("detect register layout wrong");
	a_timer_step: assert property (dec_en && !wr_timer
		&& timer_r != 8'h00 |=> timer_r == $past(timer_r) - 8'h01)
		else $error("timer did not decrement");
	a_timer_floor: assert property (timer_r == 8'h00 && !wr_timer
		|=> timer_r == 8'h00)
		else $error("timer wrapped below zero");
	a_zero_status: assert property (timer_r == 8'h01 && dec_en
		&& !wr_timer |=> timer_r == 8'h00 && tx_status_timer)
		else $error("zero status not set");
	a_live_read: assert property (pready && !pwrite && !pslverr
		&& addr8 == `OFF_TIMER |-> prdata[7:0] == $past(timer_r))
		else $error("timer read not live");
	a_ext_select: assert property (tsel_r && !tick_r
		&& !(ext_s2_r && !ext_s3_r) |-> !dec_en)
		else $error("timer counted without external edge");

	// Set must survive a reload in the same cycle
	a_status_wins: assert property (dec_en && timer_r == 8'h01
		|=> tx_status_timer)
		else $error("zero status lost to reload");
	a_status_clear: assert property (wr_timer
		&& !(dec_en && timer_r == 8'h01) |=> !tx_status_timer)
		else $error("zero status not cleared by load");

	c_cell_wait: cover property (state_r == st_cell && recov_r != 6'h00);
	c_timer_zero: cover property ($rose(tx_status_timer));
	c_both_detect: cover property (det_a && det_b);

endmodule : serial_cell_shared_support

// *** verification/serial_cell_model.sv ***
// Behavioural serial cell on the far side of the cell bus
// Assumes the cell bus runs on pclk; slow adds three wait cycles
`timescale 1ns/1ps
module serial_cell_model
	import serial_support_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire logic cell_req,
	input cell_req_type cell_cmd,
	output logic cell_ack,
	output logic [7:0] cell_rdata,
	output logic cell_rts_a,
	output logic cell_txd_a,
	output logic cell_rts_b,
	output logic cell_txd_b
);
	logic [2:0] wait_r;
	logic [7:0] byte_r;
	logic ack_nxt;
	// ----------------------------------------
	// Answer
	// ----------------------------------------
	assign ack_nxt = cell_req && !cell_ack && wait_r == (slow ? 3'h3 : 3'h0);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_r <= 3'h0;
			cell_ack <= 1'b0;
			byte_r <= 8'h00;
			cell_rdata <= 8'hFF;
		end else begin
			cell_ack <= ack_nxt;
			wait_r <= (cell_req && !cell_ack) ? wait_r + 3'h1 : 3'h0;
			// Data only valid on the ack cycle, inverted otherwise
			cell_rdata <= ack_nxt ? byte_r : ~byte_r;
			if (ack_nxt && cell_cmd.write) begin
				byte_r <= cell_cmd.wdata;
			end
		end
	end
	// Idle line levels
	assign cell_rts_a = 1'b0;
	assign cell_txd_a = 1'b1;
	assign cell_rts_b = 1'b0;
	assign cell_txd_b = 1'b1;
endmodule : serial_cell_model

// *** verification/tb.sv ***
// Self-checking bench for the serial cell support block
// Assumes serial_cell_model as cell; APB master driven here
`timescale 1ns/1ps
module tb
	import serial_support_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, cell_rdata;
	logic [31:0] pwdata, prdata, q;
	cell_req_type cell_cmd;
	logic cell_req, cell_ack, ext_clk, slow, e, req_d;
	logic crts_a, ctxd_a, crts_b, ctxd_b, rxd_a, rxd_b;
	logic rts_a, rts_a_oe_n, txd_a, txd_a_oe_n;
	logic rts_b, rts_b_oe_n, txd_b, txd_b_oe_n;
	logic ab_a, ab_b, tst;
	int fails, checked, since, gap;
	logic [7:0] rst_addr [5] = '{8'h60, 8'h70, 8'h80, 8'h90, 8'hA0};

	serial_cell_shared_support #(.BIT_CYCLES(4)) u_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cell_cmd(cell_cmd), .cell_req(cell_req),
		.cell_ack(cell_ack), .cell_rdata(cell_rdata), .ext_clk(ext_clk),
		.cell_rts_a(crts_a), .cell_txd_a(ctxd_a), .rxd_a(rxd_a),
		.rts_a(rts_a), .rts_a_oe_n(rts_a_oe_n), .txd_a(txd_a),
		.txd_a_oe_n(txd_a_oe_n), .cell_rts_b(crts_b), .cell_txd_b(ctxd_b),
		.rxd_b(rxd_b), .rts_b(rts_b), .rts_b_oe_n(rts_b_oe_n),
		.txd_b(txd_b), .txd_b_oe_n(txd_b_oe_n), .abort_status_a(ab_a),
		.abort_status_b(ab_b), .tx_status_timer(tst));
	serial_cell_model u_cell (.pclk(pclk), .presetn(presetn), .slow(slow),
		.cell_req(cell_req), .cell_cmd(cell_cmd), .cell_ack(cell_ack),
		.cell_rdata(cell_rdata), .cell_rts_a(crts_a), .cell_txd_a(ctxd_a),
		.cell_rts_b(crts_b), .cell_txd_b(ctxd_b));

	always #5 pclk = ~pclk;
	// ----------------------------------------
	// Recovery gap: ack cycle to next request
	// ----------------------------------------
	always @(negedge pclk) begin
		since = (cell_ack === 1'b1) ? 0 : since + 1;
		if (cell_req === 1'b1 && req_d === 1'b0) gap = since;
		req_d = cell_req;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x) begin
			$display("[FAIL] %s exp %h got %h", n, x, g);
			fails++;
		end
	endtask : chk
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		// Request held until pready is seen at a rising edge
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 300);
		if (n >= 300) fails++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(a, 1'b0, 32'h0000_0000);
		chk("read", x, q);
	endtask : rd
	task automatic ext_edge(input int k);
		repeat (k) begin
			repeat (4) @(posedge pclk);
			ext_clk <= 1'b1;
			repeat (4) @(posedge pclk);
			ext_clk <= 1'b0;
		end
	endtask : ext_edge
	task automatic close_out;
		if (fails == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : close_out
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{pclk, psel, penable, pwrite, ext_clk, slow, rxd_a, req_d} = '0;
		{paddr, pwdata, fails, checked, gap} = '0;
		{presetn, rxd_b, since} = {1'b0, 1'b1, 100};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rst_addr[i]) rd(rst_addr[i], 32'h0000_0000);
		chk("txd idle", 32'h0000_0003, {txd_a, txd_b});
		apb(8'hB0, 1'b1, 32'h0000_0011);
		chk("unmapped err", 32'h0000_0001, 32'(e));
		chk("unmapped data", 32'h0000_0000, q);
		apb(8'h60, 1'b1, 32'h0000_00FF);
		rd(8'h60, 32'h0000_003F);
		apb(8'h60, 1'b1, 32'h0000_0014);
		slow <= 1'b1;
		apb(8'h10, 1'b1, 32'h0000_005A);
		rd(8'h10, 32'h0000_005A);
		chk("gap", 32'h0000_0001, 32'(gap >= 20 && gap <= 24));
		chk("armless b", 32'h0000_0000, 32'(ab_b));
		apb(8'h70, 1'b1, 32'h0000_0001);
		repeat (3) @(posedge pclk);
		chk("rts a", 32'h0000_0001, 32'(rts_a));
		rxd_a <= 1'b1;
		repeat (120) @(posedge pclk);
		chk("float a", 32'h0000_0007, {ab_a, rts_a_oe_n, txd_a_oe_n});
		rd(8'h90, 32'h0000_0002);
		rxd_a <= 1'b0;
		rd(8'h90, 32'h0000_0002);
		apb(8'h70, 1'b1, 32'h0000_0000);
		rd(8'h90, 32'h0000_0000);
		apb(8'h80, 1'b1, 32'h0000_0001);
		repeat (120) @(posedge pclk);
		rd(8'h90, 32'h0000_0001);
		chk("status b", 32'h0000_0001, 32'(ab_b));
		chk("float b", 32'h0000_0007, {rts_b, rts_b_oe_n, txd_b_oe_n});
		apb(8'hA0, 1'b1, 32'hFFFF_FF05);
		rd(8'hA0, 32'h0001_0005);
		chk("tstat clr", 32'h0000_0000, 32'(tst));
		ext_edge(1);
		rd(8'hA0, 32'h0001_0004);
		ext_edge(5);
		rd(8'hA0, 32'h0001_0000);
		chk("tstat", 32'h0000_0001, 32'(tst));
		apb(8'hA0, 1'b1, 32'h0000_0002);
		repeat (300) @(posedge pclk);
		rd(8'hA0, 32'h0000_0000);
		chk("tstat tick", 32'h0000_0001, 32'(tst));
		close_out();
	end
	// Whole run is under a thousand cycles
	initial begin
		#100000;
		fails++;
		close_out();
	end
endmodule : tb
